// ### rsm_pkg.sv
// rsm_pkg: constants, register map and carrier types for the relay
// setup memory command executor.
// assumes: one 100 MHz clock, registers reached over a plain strobe port.
package rsm_pkg;

   // ****************************************************************
   // sizes and setup numbering
   // ****************************************************************
   localparam int         ADDR_W       = 8;
   localparam int         DATA_W       = 32;
   localparam int         STEP_W       = 7;
   localparam int         ROW_W        = 8;
   localparam int         CLK_MHZ      = 100;
   localparam int         CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam logic [6:0] LIVE_SETUP   = 7'h00;
   localparam logic [6:0] FIRST_SETUP  = 7'h01;
   localparam logic [6:0] LAST_SETUP   = 7'h64;
   localparam logic [6:0] STEP_ONE     = 7'h01;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFF_CMD     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_XP_SEL  = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_XP_DATA = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_MODE    = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_DOUT    = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_SETTLE  = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_ROWS    = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_CFG     = 8'h20;

   // ****************************************************************
   // command codes
   // ****************************************************************
   localparam logic [1:0] CMD_CLEAR   = 2'h1;
   localparam logic [1:0] CMD_DELETE  = 2'h2;
   localparam logic [1:0] CMD_RESTORE = 2'h3;

   // ****************************************************************
   // field defaults
   // ****************************************************************
   localparam logic       TRIG_EDGE_FALL = 1'b0;
   localparam logic       READY_NEG_TRUE = 1'b0;
   localparam logic       TRIG_DISABLED  = 1'b0;
   localparam logic [2:0] TRIG_SRC_EXT   = 3'h7;
   localparam logic [1:0] FMT_FULL       = 2'h0;
   localparam logic [1:0] EOI_LAST_HOLD  = 2'h0;
   localparam logic [1:0] TERM_CR_LF     = 2'h0;
   localparam logic [7:0] SRQ_NONE       = 8'h00;
   localparam logic [15:0] DOUT_LOW      = 16'h0000;
   localparam logic [15:0] SETTLE_ZERO   = 16'h0000;
   localparam logic [ROW_W-1:0] ROWS_NONE = 8'h00;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DEL  = 3'b010,
      ST_RST  = 3'b100
   } rsm_fsm_t;

   typedef struct packed {
      logic [1:0]        code;
      logic [STEP_W-1:0] param;
   } rsm_cmd_t;

   typedef struct packed {
      logic [7:0]        srq_mask;
      logic [STEP_W-1:0] edit_ptr;
      logic [1:0]        term;
      logic [1:0]        eoi;
      logic [1:0]        fmt;
      logic [2:0]        trig_src;
      logic              trig_en;
      logic              ready_pol;
      logic              trig_edge;
   } rsm_mode_t;

   typedef struct packed {
      rsm_mode_t   mode;
      logic [15:0] dout;
      logic [15:0] settle;
   } rsm_ddc_t;

   typedef struct packed {
      logic [ROW_W-1:0] brk_make;
      logic [ROW_W-1:0] make_brk;
   } rsm_rows_t;

   typedef struct packed {
      logic       master;
      logic [4:0] bus_addr;
   } rsm_cfg_t;

   typedef struct packed {
      logic              err;
      logic              busy;
      logic              blank;
      logic [STEP_W-1:0] relay_step;
      logic [STEP_W-1:0] mem_step;
   } rsm_status_t;

   localparam rsm_mode_t MODE_DEFAULT = '{
      srq_mask:  SRQ_NONE,
      edit_ptr:  LIVE_SETUP,
      term:      TERM_CR_LF,
      eoi:       EOI_LAST_HOLD,
      fmt:       FMT_FULL,
      trig_src:  TRIG_SRC_EXT,
      trig_en:   TRIG_DISABLED,
      ready_pol: READY_NEG_TRUE,
      trig_edge: TRIG_EDGE_FALL
   };
   localparam rsm_ddc_t DDC_DEFAULT = '{
      mode:   MODE_DEFAULT,
      dout:   DOUT_LOW,
      settle: SETTLE_ZERO
   };
   localparam rsm_rows_t ROWS_DEFAULT = '{
      brk_make: ROWS_NONE,
      make_brk: ROWS_NONE
   };

endpackage

// ### rsm_cmd_exec.sv
// rsm_cmd_exec: clear, delete and restore commands on the live relay
// setup and the 100 stored setups, plus the operating parameters.
// assumes: a parser writes commands into the command register; trigger
// logic outside waits while busy_o is high.
//
// Summary of operation
// - clear zero opens all live relays now
// - clear 1..100 empties that stored setup only
// - delete takes setups 1..100 only
// - delete shifts setups above n down one
// - after shift, setup 100 is emptied
// - display blanked while delete runs
// - restore zero erases all stored setups
// - restore clears make/break and break/make rows
// - restore opens relays, pointers to 0, 1
// - restore: trigger on falling external edge
// - restore: settled output negative true
// - restore: edit pointer at live setup
// - restore: triggers off, external source
// - restore: full format, one talk
// - restore: EOI on last byte, hold-off
// - restore: all service requests masked
// - restore: outputs low, settling zero
// - restore: no rows selected either way
// - restore: terminator carriage return, line feed
// - restore keeps bus address and master flag
// - digital output zero bit drives line low
`timescale 1ns/1ps

module rsm_cmd_exec #(
   parameter int         XPT_W        = 32,
   parameter logic [4:0] BUS_ADDR_DEF = 5'h12,
   parameter logic       MASTER_DEF   = 1'b1
) (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_b_i,
   // register port
   input  wire logic [rsm_pkg::ADDR_W-1:0]   reg_addr_i,
   input  wire logic [rsm_pkg::DATA_W-1:0]   reg_wdata_i,
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   output logic      [rsm_pkg::DATA_W-1:0]   reg_rdata_o,
   // relays and operating parameters
   output logic      [XPT_W-1:0]             relay_o,
   output rsm_pkg::rsm_ddc_t                 ddc_o,
   output rsm_pkg::rsm_rows_t                rows_o,
   output rsm_pkg::rsm_cfg_t                 cfg_o,
   output logic      [rsm_pkg::STEP_W-1:0]   relay_step_o,
   output logic      [rsm_pkg::STEP_W-1:0]   mem_step_o,
   // sequencing
   output logic                              disp_blank_o,
   output logic                              busy_o
);
   import rsm_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      rsm_fsm_t          st;
      logic [STEP_W-1:0] idx;
      logic              err;
      logic [DATA_W-1:0] rdata;
      logic [XPT_W-1:0]  live;
      rsm_ddc_t          ddc;
      rsm_rows_t         rows;
      rsm_cfg_t          cfg;
      logic [STEP_W-1:0] relay_step;
      logic [STEP_W-1:0] mem_step;
      logic [STEP_W-1:0] xp_sel;
   } rsm_state_t;

   rsm_state_t        s_reg;
   rsm_state_t        s_next;
   logic [XPT_W-1:0]  setup_mem [FIRST_SETUP:LAST_SETUP];
   logic              mem_we;
   logic [STEP_W-1:0] mem_wa;
   logic [XPT_W-1:0]  mem_wd;
   rsm_cmd_t          cmd;
   logic              cmd_wr;
   logic              cmd_take;
   rsm_status_t       status;

   function automatic logic is_stored(input logic [STEP_W-1:0] n);
      is_stored = (n >= FIRST_SETUP) && (n <= LAST_SETUP);
   endfunction

   assign cmd      = rsm_cmd_t'(reg_wdata_i[$bits(rsm_cmd_t)-1:0]);
   assign cmd_wr   = reg_wr_i && (reg_addr_i == OFF_CMD);
   assign cmd_take = cmd_wr && (s_reg.st == ST_IDLE);

   always_comb begin
      status            = '0;
      status.err        = s_reg.err;
      status.busy       = (s_reg.st != ST_IDLE);
      status.blank      = (s_reg.st == ST_DEL);
      status.relay_step = s_reg.relay_step;
      status.mem_step   = s_reg.mem_step;
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_next = s_reg;
      mem_we = 1'b0;
      mem_wa = FIRST_SETUP;
      mem_wd = '0;

      // register reads, answered in the next cycle
      if (reg_rd_i) begin
         if (reg_addr_i == OFF_STATUS) begin
            s_next.rdata = DATA_W'(status);
         end else if (reg_addr_i == OFF_XP_SEL) begin
            s_next.rdata = DATA_W'(s_reg.xp_sel);
         end else if (reg_addr_i == OFF_XP_DATA) begin
            if (is_stored(s_reg.xp_sel)) begin
               s_next.rdata = DATA_W'(setup_mem[s_reg.xp_sel]);
            end else begin
               s_next.rdata = DATA_W'(s_reg.live);
            end
         end else if (reg_addr_i == OFF_MODE) begin
            s_next.rdata = DATA_W'(s_reg.ddc.mode);
         end else if (reg_addr_i == OFF_DOUT) begin
            s_next.rdata = DATA_W'(s_reg.ddc.dout);
         end else if (reg_addr_i == OFF_SETTLE) begin
            s_next.rdata = DATA_W'(s_reg.ddc.settle);
         end else if (reg_addr_i == OFF_ROWS) begin
            s_next.rdata = DATA_W'(s_reg.rows);
         end else if (reg_addr_i == OFF_CFG) begin
            s_next.rdata = DATA_W'(s_reg.cfg);
         end else begin
            s_next.rdata = '0;
         end
      end

      // software clear of the error flag; any new error below wins
      if (reg_wr_i && (reg_addr_i == OFF_STATUS)) begin
         s_next.err = 1'b0;
      end

      case (s_reg.st)
         ST_IDLE: begin
            if (cmd_take) begin
               case (cmd.code)
                  CMD_CLEAR: begin
                     if (cmd.param == LIVE_SETUP) begin
                        s_next.live = '0;
                     end else if (is_stored(cmd.param)) begin
                        mem_we = 1'b1;
                        mem_wa = cmd.param;
                        mem_wd = '0;
                     end else begin
                        s_next.err = 1'b1;
                     end
                  end
                  CMD_DELETE: begin
                     if (is_stored(cmd.param)) begin
                        s_next.st  = ST_DEL;
                        s_next.idx = cmd.param;
                     end else begin
                        s_next.err = 1'b1;
                     end
                  end
                  CMD_RESTORE: begin
                     if (cmd.param == LIVE_SETUP) begin
                        s_next.st         = ST_RST;
                        s_next.idx        = FIRST_SETUP;
                        s_next.rows       = ROWS_DEFAULT;
                        s_next.live       = '0;
                        s_next.relay_step = LIVE_SETUP;
                        s_next.mem_step   = FIRST_SETUP;
                        s_next.ddc        = DDC_DEFAULT;
                        // cfg left alone on purpose
                        // terminator default included
                     end else begin
                        s_next.err = 1'b1;
                     end
                  end
                  default: begin
                     s_next.err = 1'b1;
                  end
               endcase
            end else if (reg_wr_i) begin
               if (reg_addr_i == OFF_XP_SEL) begin
                  if (reg_wdata_i[STEP_W-1:0] <= LAST_SETUP) begin
                     s_next.xp_sel = reg_wdata_i[STEP_W-1:0];
                  end else begin
                     s_next.err = 1'b1;
                  end
               end else if (reg_addr_i == OFF_XP_DATA) begin
                  if (is_stored(s_reg.xp_sel)) begin
                     mem_we = 1'b1;
                     mem_wa = s_reg.xp_sel;
                     mem_wd = reg_wdata_i[XPT_W-1:0];
                  end else begin
                     s_next.live = reg_wdata_i[XPT_W-1:0];
                  end
               end else if (reg_addr_i == OFF_MODE) begin
                  s_next.ddc.mode =
                     rsm_mode_t'(reg_wdata_i[$bits(rsm_mode_t)-1:0]);
               end else if (reg_addr_i == OFF_DOUT) begin
                  s_next.ddc.dout = reg_wdata_i[15:0];
               end else if (reg_addr_i == OFF_SETTLE) begin
                  s_next.ddc.settle = reg_wdata_i[15:0];
               end else if (reg_addr_i == OFF_ROWS) begin
                  s_next.rows =
                     rsm_rows_t'(reg_wdata_i[$bits(rsm_rows_t)-1:0]);
               end else if (reg_addr_i == OFF_CFG) begin
                  s_next.cfg =
                     rsm_cfg_t'(reg_wdata_i[$bits(rsm_cfg_t)-1:0]);
               end
            end
         end
         ST_DEL: begin
            mem_we = 1'b1;
            mem_wa = s_reg.idx;
            if (s_reg.idx < LAST_SETUP) begin
               mem_wd     = setup_mem[s_reg.idx + STEP_ONE];
               s_next.idx = s_reg.idx + STEP_ONE;
            end else begin
               mem_wd    = '0;
               s_next.st = ST_IDLE;
            end
         end
         ST_RST: begin
            mem_we = 1'b1;
            mem_wa = s_reg.idx;
            mem_wd = '0;
            if (s_reg.idx == LAST_SETUP) begin
               s_next.st = ST_IDLE;
            end else begin
               s_next.idx = s_reg.idx + STEP_ONE;
            end
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase

      // commands while busy are refused and flagged
      if (cmd_wr && (s_reg.st != ST_IDLE)) begin
         s_next.err = 1'b1;
      end
   end

   // ****************************************************************
   // registers and setup memory
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_reg            <= '0;
         s_reg.st         <= ST_IDLE;
         s_reg.idx        <= FIRST_SETUP;
         s_reg.ddc        <= DDC_DEFAULT;
         s_reg.rows       <= ROWS_DEFAULT;
         s_reg.cfg.master <= MASTER_DEF;
         s_reg.cfg.bus_addr <= BUS_ADDR_DEF;
         s_reg.relay_step <= LIVE_SETUP;
         s_reg.mem_step   <= FIRST_SETUP;
      end else begin
         s_reg <= s_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         setup_mem[mem_wa] <= mem_wd;
      end
   end

   assign reg_rdata_o  = s_reg.rdata;
   assign relay_o      = s_reg.live;
   assign ddc_o        = s_reg.ddc;
   assign rows_o       = s_reg.rows;
   assign cfg_o        = s_reg.cfg;
   assign relay_step_o = s_reg.relay_step;
   assign mem_step_o   = s_reg.mem_step;
   assign disp_blank_o = (s_reg.st == ST_DEL);
   assign busy_o       = (s_reg.st != ST_IDLE);

   // ****************************************************************
   // assertions
   // ****************************************************************
   clr_live_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cmd_take && cmd.code == CMD_CLEAR && cmd.param == LIVE_SETUP
      |=> relay_o == '0) else $error("live clear failed");

   clr_stored_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cmd_take && cmd.code == CMD_CLEAR && is_stored(cmd.param)
      |-> mem_we && mem_wa == cmd.param && mem_wd == '0
          ##1 $stable(relay_o)) else $error("stored clear failed");

   del_range_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cmd_take && cmd.code == CMD_DELETE && !is_stored(cmd.param)
      |=> !busy_o && status.err) else $error("bad delete taken");

   del_shift_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_reg.st == ST_DEL && s_reg.idx < LAST_SETUP
      |-> mem_we && mem_wd == setup_mem[s_reg.idx + STEP_ONE]
          ##1 mem_wa == $past(mem_wa) + STEP_ONE)
      else $error("delete shift wrong");

   del_last_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_reg.st == ST_DEL && s_reg.idx == LAST_SETUP
      |-> mem_we && mem_wa == LAST_SETUP && mem_wd == '0
          ##1 !busy_o) else $error("setup 100 not emptied");

   del_blank_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cmd_take && cmd.code == CMD_DELETE && is_stored(cmd.param)
      |=> disp_blank_o [*1] ##[0:100] !disp_blank_o)
      else $error("display not blanked");

   rst_erase_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cmd_take && cmd.code == CMD_RESTORE && cmd.param == LIVE_SETUP
      |=> (mem_we && mem_wd == '0) [*8] ##93 !busy_o)
      else $error("restore erase wrong");

   rst_defaults_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cmd_take && cmd.code == CMD_RESTORE && cmd.param == LIVE_SETUP
      |=> ddc_o == DDC_DEFAULT && rows_o == ROWS_DEFAULT && relay_o == '0
          && relay_step_o == LIVE_SETUP && mem_step_o == FIRST_SETUP)
      else $error("restore defaults wrong");

   rst_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cmd_take && cmd.code == CMD_RESTORE |=> $stable(cfg_o))
      else $error("restore changed bus config");

   busy_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      busy_o && reg_wr_i && reg_addr_i != OFF_STATUS
      |=> $stable(ddc_o) && $stable(rows_o) && $stable(cfg_o)
          && $stable(relay_o))
      else $error("write acted on while busy");

   busy_cmd_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      busy_o && cmd_wr |=> status.err)
      else $error("command taken while busy");

   dout_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !busy_o && reg_wr_i && reg_addr_i == OFF_DOUT
      |=> ddc_o.dout == 16'($past(reg_wdata_i)))
      else $error("digital output write lost");

endmodule

// ### rsm_host.sv
// rsm_host: bus controller model that sends commands and parameters
// to the executor as single-cycle register strobes.
// assumes: the design samples strobes on the rising edge of clk_i.
`timescale 1ns/1ps

module rsm_host (
   // clock
   input  wire logic                       clk_i,
   // register port
   output logic      [rsm_pkg::ADDR_W-1:0] reg_addr_o,
   output logic      [rsm_pkg::DATA_W-1:0] reg_wdata_o,
   output logic                            reg_wr_o,
   output logic                            reg_rd_o,
   input  wire logic [rsm_pkg::DATA_W-1:0] reg_rdata_i
);
   import rsm_pkg::*;

   initial begin
      reg_addr_o  = 8'h00;
      reg_wdata_o = 32'h0000_0000;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
   end

   // ****************************************************************
   // bus cycles
   // ****************************************************************
   // released data line shows the inverse, never the old value
   task automatic wr(input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge clk_i);
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= ~d;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a,
                     output logic [DATA_W-1:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge clk_i);
      reg_rd_o   <= 1'b0;
      #1;
      d = reg_rdata_i;
   endtask

   // delete is only sent with stored setups unless a refusal is meant
   task automatic cmd(input logic [1:0] code, input logic [6:0] p);
      wr(OFF_CMD, {23'h0, code, p});
   endtask
endmodule

// ### relay_setup_memory_commands_bench.sv
// relay_setup_memory_commands_bench: self-checking bench for the
// clear, delete and restore commands against a queue-free array model.
// assumes: rsm_pkg, rsm_cmd_exec and rsm_host are compiled first.
`timescale 1ns/1ps

module relay_setup_memory_commands_bench;
   import rsm_pkg::*;

   logic              clk_i;
   logic              rst_b_i;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic [31:0]       relay_o;
   rsm_ddc_t          ddc_o;
   rsm_rows_t         rows_o;
   rsm_cfg_t          cfg_o;
   logic [STEP_W-1:0] relay_step_o;
   logic [STEP_W-1:0] mem_step_o;
   logic              disp_blank_o;
   logic              busy_o;
   int                num_errors;
   int                samples_checked;
   int                cycles;
   int                seed;
   logic [31:0]       mem [0:100];
   logic [31:0]       live;

   // ****************************************************************
   // clock, host model and design
   // ****************************************************************
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   rsm_host host (
      .clk_i       (clk_i),
      .reg_addr_o  (reg_addr),
      .reg_wdata_o (reg_wdata),
      .reg_wr_o    (reg_wr),
      .reg_rd_o    (reg_rd),
      .reg_rdata_i (reg_rdata)
   );

   rsm_cmd_exec DUT (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .reg_addr_i   (reg_addr),
      .reg_wdata_i  (reg_wdata),
      .reg_wr_i     (reg_wr),
      .reg_rd_i     (reg_rd),
      .reg_rdata_o  (reg_rdata),
      .relay_o      (relay_o),
      .ddc_o        (ddc_o),
      .rows_o       (rows_o),
      .cfg_o        (cfg_o),
      .relay_step_o (relay_step_o),
      .mem_step_o   (mem_step_o),
      .disp_blank_o (disp_blank_o),
      .busy_o       (busy_o)
   );

   // ****************************************************************
   // checking helpers
   // ****************************************************************
   task automatic finish_test();
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("Error at %0t: run too long", $time);
         finish_test();
      end
   end

   // bounded wait on busy, display blank compared every cycle
   task automatic wait_idle(input logic blank_exp);
      int n;
      n = 0;
      #1;
      while (busy_o === 1'b1 && n < 300) begin
         check(disp_blank_o, blank_exp);
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n == 300) begin
         num_errors++;
         $display("Error at %0t: busy never dropped", $time);
      end
   endtask

   task automatic check_all();
      logic [31:0] v;
      for (int i = 1; i <= 100; i++) begin
         host.wr(OFF_XP_SEL, 32'(i));
         host.rd(OFF_XP_DATA, v);
         check(v, mem[i]);
      end
   endtask

   task automatic restore_chk();
      host.wr(OFF_MODE, 32'($random(seed)) & 32'h07F7_FFFF);
      host.wr(OFF_DOUT, 32'($random(seed)) & 32'h0000_FFFF);
      host.wr(OFF_SETTLE, 32'($random(seed)) & 32'h0000_FFFF);
      host.wr(OFF_ROWS, 32'($random(seed)) & 32'h0000_FFFF);
      host.wr(OFF_CFG, 32'h0000_0025);
      host.cmd(CMD_RESTORE, 7'h00);
      host.wr(OFF_DOUT, 32'h0000_00FF);
      wait_idle(1'b0);
      check(ddc_o, DDC_DEFAULT);
      check(rows_o, ROWS_DEFAULT);
      check(relay_o, 32'h0);
      check(relay_step_o, LIVE_SETUP);
      check(mem_step_o, FIRST_SETUP);
      check(cfg_o, 6'h25);
      for (int i = 0; i <= 100; i++) begin
         mem[i] = 32'h0;
      end
      live = 32'h0;
      check_all();
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [31:0] v;
      int          dels [3];
      rst_b_i         = 1'b0;
      seed            = 7389;
      num_errors      = 0;
      samples_checked = 0;
      cycles          = 0;
      dels            = '{50, 100, 1};
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      #1;
      check(mem_step_o, FIRST_SETUP);
      check(relay_o, 32'h0);
      check(busy_o, 1'b0);
      check(ddc_o, DDC_DEFAULT);
      restore_chk();
      // fill live and stored setups
      live = 32'($random(seed));
      host.wr(OFF_XP_SEL, 32'h0);
      host.wr(OFF_XP_DATA, live);
      for (int i = 1; i <= 100; i++) begin
         mem[i] = 32'($random(seed));
         host.wr(OFF_XP_SEL, 32'(i));
         host.wr(OFF_XP_DATA, mem[i]);
      end
      host.cmd(CMD_CLEAR, 7'd20);
      mem[20] = 32'h0;
      #1;
      check(relay_o, live);
      host.cmd(CMD_CLEAR, 7'd0);
      #1;
      check(relay_o, 32'h0);
      // deletes, the last with a command sent while busy
      foreach (dels[j]) begin
         host.cmd(CMD_DELETE, 7'(dels[j]));
         if (dels[j] == 1) begin
            host.cmd(CMD_CLEAR, 7'd30);
         end
         for (int k = dels[j]; k < 100; k++) begin
            mem[k] = mem[k + 1];
         end
         mem[100] = 32'h0;
         wait_idle(1'b1);
         check_all();
      end
      host.rd(OFF_STATUS, v);
      check(v[16], 1'b1);
      host.wr(OFF_STATUS, 32'h0);
      host.rd(OFF_STATUS, v);
      check(v[16], 1'b0);
      host.cmd(CMD_DELETE, 7'd0);
      host.rd(OFF_STATUS, v);
      check(v[16:15], 2'b10);
      v = 32'($random(seed)) & 32'h0000_FFFF;
      host.wr(OFF_DOUT, v);
      #1;
      check(ddc_o.dout, v[15:0]);
      restore_chk();
      finish_test();
   end
endmodule
